// ===== shared/host_port_pkg.sv
package host_port_pkg;
   // ****************************************
   // Link framing
   // ****************************************
   localparam int BYTE_BITS = 8;
   localparam int WORD_BITS = 32;
   localparam int BUF_WORDS = 64;
   localparam int IDX_W = 6;
   localparam int STATUS_RX_BIT = 0;
   localparam int STATUS_Q_BIT = 1;
   localparam logic [7:0] PAD_BYTE = 8'h00;
   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_MHZ = 100;
   localparam int SCK_HALF_NS = 80;
   localparam int SCK_HALF_CYC = (SCK_HALF_NS * CLK_MHZ + 999) / 1000;
   localparam int SEL_GAP_NS = 200;
   localparam int SEL_GAP_CYC = (SEL_GAP_NS * CLK_MHZ + 999) / 1000;
   localparam logic [7:0] DIV_RST = 8'h00;
   // ****************************************
   // APB register map
   // ****************************************
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_STATUS = 8'h04;
   localparam logic [7:0] OFF_TXCNT = 8'h08;
   localparam logic [7:0] OFF_RXINFO = 8'h0C;
   localparam logic [7:0] OFF_BUF_IDX = 8'h10;
   localparam logic [7:0] OFF_TXDATA = 8'h14;
   localparam logic [7:0] OFF_RXDATA = 8'h18;
   localparam int CTRL_START = 0;
   localparam int CTRL_RXEN = 1;
   localparam int CTRL_CPOL = 2;
   localparam int CTRL_CPHA = 3;
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   typedef enum {ST_IDLE, ST_RUN, ST_GAP} xfer_state_e;
   function automatic logic [7:0] status_byte(input logic rx_ok, input logic queued);
      status_byte = {6'b00_0000, queued, rx_ok};
   endfunction
endpackage

// ===== design/edge_finder.sv
`timescale 1ns/1ns
module edge_finder (
   input wire logic clk_in,
   input wire logic srst_in,
   input wire logic async_in,
   output logic level_out,
   output logic rise_out,
   output logic fall_out
);
   logic meta_reg;
   logic sync_reg;
   logic prev_reg;
   // ****************************************
   // Two-flop synchroniser and edge detect
   // ****************************************
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
         prev_reg <= 1'b0;
      end else begin
         meta_reg <= async_in;
         sync_reg <= meta_reg;
         prev_reg <= sync_reg;
      end
   end
   assign level_out = sync_reg;
   assign rise_out = sync_reg & ~prev_reg;
   assign fall_out = ~sync_reg & prev_reg;
endmodule

// ===== design/clock_divider.sv
`timescale 1ns/1ns
module clock_divider (
   input wire logic clk_in,
   input wire logic srst_in,
   input wire logic run_in,
   output logic tick_out
);
   import host_port_pkg::*;
   logic [7:0] cnt_reg;
   // ****************************************
   // Half-period enable pulse
   // ****************************************
   always_ff @(posedge clk_in) begin
      if (srst_in || !run_in) begin
         cnt_reg <= DIV_RST;
         tick_out <= 1'b0;
      end else if (cnt_reg == 8'(SCK_HALF_CYC - 1)) begin
         cnt_reg <= DIV_RST;
         tick_out <= 1'b1;
      end else begin
         cnt_reg <= cnt_reg + 8'h01;
         tick_out <= 1'b0;
      end
   end
endmodule

// ===== design/host_message_master.sv
// The register offsets and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ns
module host_message_master (
   input wire logic clk_in,
   input wire logic srst_in,
   input wire logic [7:0] paddr_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   output logic host_serial_clock_out,
   output logic host_serial_in_out,
   output logic host_slave_select_n_out,
   input wire logic host_serial_out_in,
   input wire logic host_attention_in
);
   import host_port_pkg::*;

   // ****************************************
   // Storage and control
   // ****************************************
   logic [31:0] tx_mem_reg [BUF_WORDS];
   logic [31:0] rx_mem_reg [BUF_WORDS];
   logic [31:0] ctrl_reg;
   logic [7:0] tx_cnt_reg;
   logic [IDX_W-1:0] buf_idx_reg;
   logic [7:0] rx_len_reg;
   logic [7:0] dev_status_reg;
   logic rx_done_reg;
   logic busy_reg;
   logic [31:0] prdata_reg;
   xfer_state_e state_reg;
   logic [7:0] gap_reg;
   logic phase_reg;
   logic sck_reg;
   logic mosi_reg;
   logic sel_n_reg;
   logic [31:0] sh_out_reg;
   logic [31:0] sh_in_reg;
   logic [5:0] bit_reg;
   logic [1:0] seg_reg;
   logic [7:0] words_reg;
   logic [7:0] tx_len_reg;
   logic [7:0] dev_len_reg;
   logic [IDX_W-1:0] word_reg;
   logic tick;
   logic miso_s;
   logic attn_s;
   logic cpol;
   logic cpha;
   logic access;
   logic seg_last;
   logic [7:0] span;
   logic lead_edge;
   logic sample_edge;
   logic shift_edge;
   logic [31:0] sampled;
   logic [7:0] host_status;

   assign cpol = ctrl_reg[CTRL_CPOL];
   assign cpha = ctrl_reg[CTRL_CPHA];
   assign access = psel_in & penable_in;

   edge_finder u_miso (
      .clk_in(clk_in),
      .srst_in(srst_in),
      .async_in(host_serial_out_in),
      .level_out(miso_s),
      .rise_out(),
      .fall_out()
   );
   edge_finder u_attn (
      .clk_in(clk_in),
      .srst_in(srst_in),
      .async_in(host_attention_in),
      .level_out(attn_s),
      .rise_out(),
      .fall_out()
   );
   clock_divider u_div (
      .clk_in(clk_in),
      .srst_in(srst_in),
      .run_in(state_reg == ST_RUN),
      .tick_out(tick)
   );

   // ****************************************
   // APB slave, zero wait states
   // ****************************************
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         ctrl_reg <= CTRL_RST;
         tx_cnt_reg <= 8'h00;
         buf_idx_reg <= '0;
      end else begin
         ctrl_reg[CTRL_START] <= 1'b0;
         if (access && pwrite_in) begin
            case (paddr_in)
               OFF_CTRL: begin
                  ctrl_reg <= {28'h000_0000, pwdata_in[3:0]};
               end
               OFF_TXCNT: begin
                  tx_cnt_reg <= pwdata_in[7:0];
               end
               OFF_BUF_IDX: begin
                  buf_idx_reg <= pwdata_in[IDX_W-1:0];
               end
               OFF_TXDATA: begin
                  buf_idx_reg <= buf_idx_reg + 1'b1;
               end
               default: begin
               end
            endcase
         end else if (access && paddr_in == OFF_RXDATA) begin
            buf_idx_reg <= buf_idx_reg + 1'b1;
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (access && pwrite_in && paddr_in == OFF_TXDATA) begin
         tx_mem_reg[buf_idx_reg] <= pwdata_in;
      end
   end

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         prdata_reg <= 32'h0000_0000;
         pready_out <= 1'b0;
         pslverr_out <= 1'b0;
      end else begin
         pready_out <= psel_in & ~penable_in;
         pslverr_out <= 1'b0;
         prdata_reg <= 32'h0000_0000;
         if (psel_in && !penable_in && !pwrite_in) begin
            case (paddr_in)
               OFF_CTRL: prdata_reg <= ctrl_reg;
               OFF_STATUS: prdata_reg <= {27'h000_0000, attn_s, rx_done_reg,
                                          busy_reg, dev_status_reg[1:0]};
               OFF_TXCNT: prdata_reg <= {24'h00_0000, tx_cnt_reg};
               OFF_RXINFO: prdata_reg <= {16'h0000, dev_len_reg, rx_len_reg};
               OFF_BUF_IDX: prdata_reg <= {26'h000_0000, buf_idx_reg};
               OFF_RXDATA: prdata_reg <= rx_mem_reg[buf_idx_reg];
               default: prdata_reg <= 32'h0000_0000;
            endcase
         end
         if (psel_in && !penable_in) begin
            pslverr_out <= !(paddr_in inside {OFF_CTRL, OFF_STATUS, OFF_TXCNT,
               OFF_RXINFO, OFF_BUF_IDX, OFF_TXDATA, OFF_RXDATA});
         end
      end
   end
   assign prdata_out = prdata_reg;

   // ****************************************
   // Serial clock edges
   // ****************************************
   // phase 0 = idle level half, phase 1 = active half
   assign lead_edge = tick & ~phase_reg;
   assign sample_edge = cpha ? (tick & phase_reg) : lead_edge;
   assign shift_edge = cpha ? lead_edge : (tick & phase_reg);
   assign sampled = {sh_in_reg[30:0], miso_s};
   assign host_status = status_byte(ctrl_reg[CTRL_RXEN], tx_cnt_reg != 8'h00);

   // Segment 0 pad/status out, 1 status in, 2 length, 3 words
   assign seg_last = (seg_reg == 2'd3) ? (bit_reg == 6'd31) : (bit_reg == 6'd7);
   assign span = (tx_len_reg > dev_len_reg) ? tx_len_reg : dev_len_reg;

   // ****************************************
   // Transfer sequencer
   // ****************************************
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         state_reg <= ST_IDLE;
         sel_n_reg <= 1'b1;
         sck_reg <= 1'b0;
         phase_reg <= 1'b0;
         mosi_reg <= 1'b0;
         sh_out_reg <= 32'h0000_0000;
         sh_in_reg <= 32'h0000_0000;
         bit_reg <= 6'd0;
         seg_reg <= 2'd0;
         words_reg <= 8'h00;
         tx_len_reg <= 8'h00;
         dev_len_reg <= 8'h00;
         rx_len_reg <= 8'h00;
         dev_status_reg <= 8'h00;
         word_reg <= '0;
         gap_reg <= 8'h00;
         busy_reg <= 1'b0;
         rx_done_reg <= 1'b0;
      end else begin
         case (state_reg)
            ST_IDLE: begin
               sck_reg <= cpol;
               phase_reg <= 1'b0;
               if (ctrl_reg[CTRL_START]) begin
                  state_reg <= ST_RUN;
                  sel_n_reg <= 1'b0;
                  busy_reg <= 1'b1;
                  rx_done_reg <= 1'b0;
                  seg_reg <= 2'd0;
                  bit_reg <= 6'd0;
                  word_reg <= '0;
                  tx_len_reg <= 8'h00;
                  dev_len_reg <= 8'h00;
                  // Leading-edge sampling mode (cpha 0) shows the first bit before any clock edge
                  sh_out_reg <= cpha ? {host_status, 24'h00_0000}
                                     : {host_status[6:0], 1'b0, 24'h00_0000};
                  mosi_reg <= cpha ? 1'b0 : host_status[7];
               end
            end
            ST_RUN: begin
               if (tick) begin
                  phase_reg <= ~phase_reg;
                  sck_reg <= ~sck_reg;
               end
               if (shift_edge) begin
                  mosi_reg <= sh_out_reg[31];
                  sh_out_reg <= {sh_out_reg[30:0], 1'b0};
               end
               if (sample_edge) begin
                  sh_in_reg <= sampled;
                  bit_reg <= bit_reg + 6'd1;
                  if (seg_last) begin
                     bit_reg <= 6'd0;
                     case (seg_reg)
                        2'd0: begin
                           seg_reg <= 2'd1;
                           sh_out_reg <= {PAD_BYTE, 24'h00_0000};
                        end
                        2'd1: begin
                           dev_status_reg <= {6'b00_0000, sampled[1:0]};
                           if (!sampled[STATUS_RX_BIT] && !sampled[STATUS_Q_BIT]) begin
                              state_reg <= ST_GAP;
                              gap_reg <= 8'h00;
                           end else begin
                              seg_reg <= 2'd2;
                              tx_len_reg <= sampled[STATUS_RX_BIT] ? tx_cnt_reg : 8'h00;
                              sh_out_reg <= {(sampled[STATUS_RX_BIT] ? tx_cnt_reg : 8'h00),
                                             24'h00_0000};
                           end
                        end
                        2'd2: begin
                           dev_len_reg <= sampled[7:0];
                           words_reg <= 8'h00;
                           word_reg <= '0;
                           sh_out_reg <= tx_mem_reg['0];
                           if (tx_len_reg == 8'h00 && sampled[7:0] == 8'h00) begin
                              state_reg <= ST_GAP;
                              gap_reg <= 8'h00;
                           end else begin
                              seg_reg <= 2'd3;
                           end
                        end
                        default: begin
                           words_reg <= words_reg + 8'h01;
                           word_reg <= word_reg + 1'b1;
                           sh_out_reg <= tx_mem_reg[word_reg + 1'b1];
                           if (words_reg + 8'h01 == span) begin
                              state_reg <= ST_GAP;
                              gap_reg <= 8'h00;
                              rx_len_reg <= dev_len_reg;
                           end
                        end
                     endcase
                  end
               end
            end
            ST_GAP: begin
               sck_reg <= cpol;
               phase_reg <= 1'b0;
               gap_reg <= gap_reg + 8'h01;
               // Select rises only once the clock is back at idle
               if (gap_reg == 8'h01) begin
                  sel_n_reg <= 1'b1;
               end
               if (gap_reg == 8'(SEL_GAP_CYC - 1)) begin
                  state_reg <= ST_IDLE;
                  busy_reg <= 1'b0;
                  rx_done_reg <= 1'b1;
               end
            end
            default: begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

   // ****************************************
   // Receive buffer write port
   // ****************************************
   logic rx_we;
   logic [IDX_W-1:0] rx_wa;
   assign rx_we = (state_reg == ST_RUN) && sample_edge && seg_last && seg_reg == 2'd3
                  && (words_reg < dev_len_reg);
   assign rx_wa = word_reg;
   always_ff @(posedge clk_in) begin
      if (rx_we) begin
         rx_mem_reg[rx_wa] <= sampled;
      end
   end

   assign host_serial_clock_out = sck_reg;
   assign host_serial_in_out = mosi_reg;
   assign host_slave_select_n_out = sel_n_reg;

   // ****************************************
   // Checks
   // ****************************************
   property p_sel_frame;
      @(posedge clk_in) disable iff (srst_in)
      (state_reg == ST_IDLE) |-> sel_n_reg;
   endproperty
   a_sel_frame: assert property (p_sel_frame) else $error("select low while idle");

   property p_no_clock_outside;
      @(posedge clk_in) disable iff (srst_in)
      sel_n_reg && $past(sel_n_reg) |-> (sck_reg == $past(cpol));
   endproperty
   a_no_clock_outside: assert property (p_no_clock_outside) else $error("clock while free");

   property p_status_bits;
      @(posedge clk_in) disable iff (srst_in)
      $rose(busy_reg) |->
         (cpha ? sh_out_reg[31:26] : {mosi_reg, sh_out_reg[31:27]}) == 6'b00_0000;
   endproperty
   a_status_bits: assert property (p_status_bits) else $error("reserved bits set");

   property p_len_gate;
      @(posedge clk_in) disable iff (srst_in)
      (seg_reg == 2'd2 && !dev_status_reg[STATUS_RX_BIT]) |-> tx_len_reg == 8'h00;
   endproperty
   a_len_gate: assert property (p_len_gate) else $error("length sent to unready peer");

   property p_stop_early;
      @(posedge clk_in) disable iff (srst_in)
      (sample_edge && seg_last && seg_reg == 2'd1 && sampled[1:0] == 2'b00)
         |=> state_reg == ST_GAP ##2 sel_n_reg;
   endproperty
   a_stop_early: assert property (p_stop_early) else $error("no early stop");

   property p_span;
      @(posedge clk_in) disable iff (srst_in)
      $rose(sel_n_reg) && seg_reg == 2'd3 |-> words_reg == span;
   endproperty
   a_span: assert property (p_span) else $error("released before span");

   property p_pready;
      @(posedge clk_in) disable iff (srst_in)
      psel_in && !penable_in |=> pready_out;
   endproperty
   a_pready: assert property (p_pready) else $error("pready missing");

   property p_done;
      @(posedge clk_in) disable iff (srst_in)
      $fell(busy_reg) |-> rx_done_reg;
   endproperty
   a_done: assert property (p_done) else $error("done flag missing");

   c_early: cover property (@(posedge clk_in) disable iff (srst_in)
      seg_reg == 2'd1 && state_reg == ST_GAP);
   c_words: cover property (@(posedge clk_in) disable iff (srst_in) rx_we);
   c_full: cover property (@(posedge clk_in) disable iff (srst_in) $fell(busy_reg));
endmodule

// ===== testbench/msg_device_model.sv
`timescale 1ns/1ns
module msg_device_model (
   input wire logic sclk_in,
   input wire logic sel_n_in,
   input wire logic mosi_in,
   input wire logic rx_enable_in,
   input wire logic post_in,
   input wire logic [7:0] post_len_in,
   output logic miso_out,
   output logic attention_out
);
   import host_port_pkg::*;
   // ****************************************
   // Device state, modes 0 and 3
   // ****************************************
   logic [31:0] rx_mem [0:BUF_WORDS-1];
   logic [7:0] tx_len = 8'h00;
   logic [7:0] dev_len = 8'h00;
   logic [7:0] host_len = 8'h00;
   logic [7:0] stat = 8'h00;
   logic [7:0] hstat = 8'h00;
   logic [7:0] rx_words = 8'h00;
   logic [31:0] sh = 32'h0000_0000;
   logic queued = 1'b0;
   logic tx_done = 1'b0;
   logic rx_avail = 1'b0;
   int bit_cnt = 0;
   initial miso_out = 1'b0;
   initial attention_out = 1'b0;

   function automatic logic [31:0] tx_word(input int i);
      tx_word = {8'hC1, 8'(i), 8'h3C, 8'h3E};
   endfunction

   function automatic logic out_bit(input int n);
      int w;
      logic [31:0] tw;
      w = (n - 24) / 32;
      tw = tx_word(w);
      if (n < 8) return PAD_BYTE[7-n];
      if (n < 16) return stat[15-n];
      if (n < 24) return dev_len[23-n];
      if (w < int'(dev_len)) return tw[31-((n-24)%32)];
      return 1'b0;
   endfunction

   // ****************************************
   // Frame start and end
   // ****************************************
   always @(negedge sel_n_in) begin
      bit_cnt = 0;
      stat = {6'b00_0000, queued, rx_enable_in};
      dev_len = 8'h00;
      host_len = 8'h00;
      rx_words = 8'h00;
      attention_out = 1'b0;
      miso_out = out_bit(0);
   end

   always @(posedge sel_n_in) begin
      if (dev_len != 8'h00 && bit_cnt >= 24 + 32 * int'(dev_len)) queued = 1'b0;
      tx_done = !queued;
      rx_avail = (rx_words != 8'h00);
      attention_out = queued;
      miso_out = ~miso_out;
   end

   always @(posedge post_in) begin
      tx_len = post_len_in;
      queued = 1'b1;
      attention_out = 1'b1;
   end

   // ****************************************
   // Shifting, sample rising, change falling
   // ****************************************
   always @(posedge sclk_in) begin
      if (!sel_n_in) begin
         sh = {sh[30:0], mosi_in};
         bit_cnt++;
         if (bit_cnt == 8) begin
            hstat = sh[7:0];
            dev_len = (queued && sh[STATUS_RX_BIT]) ? tx_len : 8'h00;
         end
         if (bit_cnt == 24) host_len = sh[7:0];
         if (bit_cnt > 24 && (bit_cnt - 24) % 32 == 0 &&
             (bit_cnt - 24) / 32 <= int'(host_len)) begin
            rx_mem[(bit_cnt - 24) / 32 - 1] = sh;
            rx_words++;
         end
      end
   end

   always @(negedge sclk_in) begin
      if (!sel_n_in) miso_out = out_bit(bit_cnt);
   end
endmodule

// ===== testbench/spi_slave_message_port_test.sv
`timescale 1ns/1ns
module spi_slave_message_port_test;
   import host_port_pkg::*;
   logic clk_in = 1'b0;
   logic srst_in = 1'b1;
   logic [7:0] paddr = 8'h00;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready, pslverr, sclk, mosi, sel_n, miso, attn;
   logic dev_rx_en = 1'b0;
   logic dev_post = 1'b0;
   logic [7:0] dev_cnt = 8'h00;
   logic [31:0] rd;
   logic err;
   int miscompares = 0;
   int samples_checked = 0;

   always #5 clk_in = ~clk_in;

   host_message_master dut (.clk_in(clk_in), .srst_in(srst_in), .paddr_in(paddr),
      .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .pwdata_in(pwdata),
      .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
      .host_serial_clock_out(sclk), .host_serial_in_out(mosi),
      .host_slave_select_n_out(sel_n), .host_serial_out_in(miso), .host_attention_in(attn));

   msg_device_model device (.sclk_in(sclk), .sel_n_in(sel_n), .mosi_in(mosi),
      .rx_enable_in(dev_rx_en), .post_in(dev_post), .post_len_in(dev_cnt),
      .miso_out(miso), .attention_out(attn));

   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic [31:0] word(input logic [7:0] seed, input int i);
      word = {seed, 8'(i), 8'h3C, 8'h3E};
   endfunction

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] wd);
      @(posedge clk_in);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= wd;
      @(posedge clk_in);
      penable <= 1'b1;
      @(posedge clk_in);
      while (pready !== 1'b1) @(posedge clk_in);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic frame(input logic [31:0] ctrl);
      apb(OFF_CTRL, 1'b1, ctrl);
      do apb(OFF_STATUS, 1'b0, 32'h0000_0000); while (rd[2] !== 1'b0);
   endtask

   task automatic post(input logic [7:0] n);
      @(posedge clk_in);
      dev_cnt <= n;
      dev_post <= 1'b1;
      @(posedge clk_in);
      dev_post <= 1'b0;
   endtask

   task automatic report_and_stop;
      $display("Checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   initial begin
      repeat (40000) @(posedge clk_in);
      miscompares++;
      report_and_stop();
   end

   // ****************************************
   // Tests
   // ****************************************
   initial begin
      repeat (10) @(posedge clk_in);
      srst_in <= 1'b0;
      @(posedge clk_in);
      check("select idle", 32'(sel_n), 32'h0000_0001);
      check("clock idle", 32'(sclk), 32'h0000_0000);
      apb(OFF_CTRL, 1'b0, 32'h0000_0000);
      check("ctrl reset", rd, CTRL_RST);
      apb(8'h40, 1'b0, 32'h0000_0000);
      check("unmapped", 32'(err), 32'h0000_0001);
      apb(OFF_CTRL, 1'b1, 32'h0000_0004);
      repeat (4) @(posedge clk_in);
      check("cpol idle", 32'(sclk), 32'h0000_0001);
      apb(OFF_CTRL, 1'b1, 32'h0000_0000);
      // Both directions at once
      dev_rx_en <= 1'b1;
      post(8'h03);
      repeat (8) @(posedge clk_in);
      apb(OFF_STATUS, 1'b0, 32'h0000_0000);
      check("attention up", 32'(rd[4]), 32'h0000_0001);
      apb(OFF_BUF_IDX, 1'b1, 32'h0000_0000);
      for (int i = 0; i < 2; i++) apb(OFF_TXDATA, 1'b1, word(8'h96, i));
      apb(OFF_TXCNT, 1'b1, 32'h0000_0002);
      frame(32'h0000_0003);
      check("status full", 32'(rd[4:0]), 32'h0000_000B);
      check("host status", 32'(device.hstat), 32'h0000_0003);
      check("bits clocked", 32'(device.bit_cnt), 32'd120);
      check("host len", 32'(device.host_len), 32'h0000_0002);
      check("rx words", 32'(device.rx_words), 32'h0000_0002);
      check("tx done", 32'(device.tx_done), 32'h0000_0001);
      check("rx avail", 32'(device.rx_avail), 32'h0000_0001);
      for (int i = 0; i < 2; i++) check("dev rx", device.rx_mem[i], word(8'h96, i));
      apb(OFF_RXINFO, 1'b0, 32'h0000_0000);
      check("rxinfo", rd, 32'h0000_0303);
      apb(OFF_BUF_IDX, 1'b1, 32'h0000_0000);
      for (int i = 0; i < 3; i++) begin
         apb(OFF_RXDATA, 1'b0, 32'h0000_0000);
         check("host rx", rd, word(8'hC1, i));
      end
      // Nothing can move: stop after status
      dev_rx_en <= 1'b0;
      apb(OFF_TXCNT, 1'b1, 32'h0000_0001);
      frame(32'h0000_0001);
      check("status none", 32'(rd[1:0]), 32'h0000_0000);
      check("short frame", 32'(device.bit_cnt), 32'd16);
      check("host status q", 32'(device.hstat), 32'h0000_0002);
      // Device sends, not ready to receive
      post(8'h01);
      frame(32'h0000_0003);
      check("zero host len", 32'(device.host_len), 32'h0000_0000);
      check("rx none", 32'(device.rx_words), 32'h0000_0000);
      check("rx avail none", 32'(device.rx_avail), 32'h0000_0000);
      check("bits one word", 32'(device.bit_cnt), 32'd56);
      check("attention down", 32'(rd[4]), 32'h0000_0000);
      apb(OFF_RXINFO, 1'b0, 32'h0000_0000);
      check("rxinfo one", rd, 32'h0000_0101);
      apb(OFF_BUF_IDX, 1'b1, 32'h0000_0000);
      apb(OFF_RXDATA, 1'b0, 32'h0000_0000);
      check("host rx one", rd, word(8'hC1, 0));
      // Clock idles high, data changes on the leading edge
      dev_rx_en <= 1'b1;
      apb(OFF_CTRL, 1'b1, 32'h0000_000E);
      post(8'h02);
      apb(OFF_BUF_IDX, 1'b1, 32'h0000_0000);
      apb(OFF_TXDATA, 1'b1, word(8'h5A, 0));
      frame(32'h0000_000F);
      check("status mode3", 32'(rd[4:0]), 32'h0000_000B);
      check("bits mode3", 32'(device.bit_cnt), 32'd88);
      check("host len mode3", 32'(device.host_len), 32'h0000_0001);
      check("dev rx mode3", device.rx_mem[0], word(8'h5A, 0));
      apb(OFF_RXINFO, 1'b0, 32'h0000_0000);
      check("rxinfo mode3", rd, 32'h0000_0202);
      apb(OFF_BUF_IDX, 1'b1, 32'h0000_0000);
      for (int i = 0; i < 2; i++) begin
         apb(OFF_RXDATA, 1'b0, 32'h0000_0000);
         check("host rx mode3", rd, word(8'hC1, i));
      end
      report_and_stop();
   end
endmodule
